// ### rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

	// =====================================================================
	// Sizes of the source and vector sets.
	localparam int NUM_SRC = 22;
	localparam int NUM_VEC = 10;
	localparam int VEC_IDX_W = 4;
	localparam int ADDR_W = 20;

	// =====================================================================
	// Vector address layout: first vector and step between vectors.
	localparam logic [ADDR_W-1:0] VEC_BASE = 20'h00003;
	localparam logic [ADDR_W-1:0] VEC_STEP = 20'h00008;

	// =====================================================================
	// Source numbering, grouped by the vector each source feeds.
	localparam int SRC_EXT_A = 0;
	localparam int SRC_EXT_B = 1;
	localparam int SRC_EXT_C = 2;
	localparam int SRC_T0_LOW = 3;
	localparam int SRC_REMOTE = 4;
	localparam int SRC_EXT_D = 5;
	localparam int SRC_BASE_TMR = 6;
	localparam int SRC_T0_HIGH = 7;
	localparam int SRC_T1_LOW = 8;
	localparam int SRC_T1_HIGH = 9;
	localparam int SRC_SYNC_SER = 10;
	localparam int SRC_UART_RX = 11;
	localparam int SRC_ASYNC_SER = 12;
	localparam int SRC_UART_TX = 13;
	localparam int SRC_ADC_DONE = 14;
	localparam int SRC_SMALL_SIG = 15;
	localparam int SRC_TIMER_SIX = 16;
	localparam int SRC_TIMER_SEVEN = 17;
	localparam int SRC_PWM_A = 18;
	localparam int SRC_PWM_B = 19;
	localparam int SRC_PORT0 = 20;
	localparam int SRC_TIMER_FOUR = 21;
	// Timer five is not among the counted sources, so its number lies past the last one.
	localparam int SRC_TIMER_FIVE_UNUSED = 22;

	// Vector index of every source, source zero in the lowest nibble; the last vector serves port zero and timer four.
	localparam logic [NUM_SRC*VEC_IDX_W-1:0] SRC_VEC_MAP = {
		4'h9, 4'h9, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h7, 4'h7, 4'h6,
		4'h6, 4'h5, 4'h5, 4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h0
	};

	// =====================================================================
	// Priority level codes; a larger code ranks higher.
	typedef enum logic [1:0] {
		LVL_NONE = 2'b00,
		LVL_LOW = 2'b01,
		LVL_HIGH = 2'b10,
		LVL_TOP = 2'b11
	} level_e;

	// Number of vectors that may take the top level instead of high.
	localparam int NUM_TOP_VEC = 2;
	localparam logic [NUM_VEC-1:0] VEC_SEL_RESET = 10'h000;

	// Request handed to the core.
	typedef struct packed {
		logic valid;
		logic [VEC_IDX_W-1:0] idx;
		logic [ADDR_W-1:0] addr;
		logic [1:0] level;
	} irq_req_s;

endpackage

// ### rtl/irq_arbiter.sv
`timescale 1ns/100ps
module irq_arbiter #(
	parameter int NUM_VEC = 10,
	parameter int IDX_W = 4
) (
	// Per-vector pending level.
	input wire logic [NUM_VEC*2-1:0] vec_level,
	// Level of the interrupt in service.
	input wire logic [1:0] service_level,
	// Winner.
	output logic win_valid,
	output logic [IDX_W-1:0] win_idx,
	output logic [1:0] win_level
);

	// =====================================================================
	// Elaboration checks: the index must be able to name every vector.
	if (IDX_W < 1 || (1 << IDX_W) < NUM_VEC) begin : g_chk
		$error("Index width too small for the vector count.");
	end

	// =====================================================================
	// Scan from the highest vector downward so the smallest index at the best level wins last.
	always_comb begin
		win_valid = 1'b0;
		win_idx = '0;
		win_level = 2'b00;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (vec_level[i*2 +: 2] != 2'b00 && vec_level[i*2 +: 2] >= win_level) begin // R03 R04
				win_level = vec_level[i*2 +: 2];
				win_idx = IDX_W'(i);
			end
		end
		win_valid = (win_level > service_level); // R02
	end

endmodule

// ### rtl/multilevel_vectored_irq_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// R01: Three levels exist, top above high above low.
// R02: During service only strictly higher levels are offered to the core.
// R03: Among simultaneous vectors the highest level wins.
// R04: Equal levels resolve to the smallest vector address.
// R05: Twenty-two sources map onto ten vectors.
// R06: Vectors at 00003H to 0004BH step eight; first two top or low, others high or low.
// R07: Vector 00043H collects converter, detector, timers six and seven, both pulse channels.
// R08: A per-vector list of latched source flags is readable.
// R09: Source flags stay set until cleared; flag with enable keeps its vector pending.
module multilevel_vectored_irq_ctrl #(
	parameter int NUM_SRC = irq_ctrl_pkg::NUM_SRC,
	parameter int NUM_VEC = irq_ctrl_pkg::NUM_VEC
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Source events, one-cycle pulses or levels.
	input wire logic [NUM_SRC-1:0] src_event,
	// Source enables and software clear strobes.
	input wire logic [NUM_SRC-1:0] src_enable,
	input wire logic [NUM_SRC-1:0] src_clear,
	// Level select per vector: 1 picks top or high, 0 picks low.
	input wire logic [NUM_VEC-1:0] vec_level_sel,
	// Core handshake.
	input wire logic core_ack,
	input wire logic core_return,
	output irq_ctrl_pkg::irq_req_s core_req,
	// Source flag list lookup.
	input wire logic [irq_ctrl_pkg::VEC_IDX_W-1:0] list_vec,
	output logic [NUM_SRC-1:0] vector_source_flag_list,
	// Status.
	output logic [NUM_SRC-1:0] src_flags,
	output logic [1:0] service_level
);

	localparam int IW = irq_ctrl_pkg::VEC_IDX_W;

	// =====================================================================
	// Elaboration checks.
	if (NUM_SRC != irq_ctrl_pkg::NUM_SRC || NUM_VEC != irq_ctrl_pkg::NUM_VEC) begin : g_chk
		$error("Source and vector counts are fixed by the vector map.");
	end

	// =====================================================================
	// Helpers.
	function automatic logic [IW-1:0] vec_of(input int s);
		return irq_ctrl_pkg::SRC_VEC_MAP[s*IW +: IW];
	endfunction

	function automatic logic [irq_ctrl_pkg::ADDR_W-1:0] vec_addr(input logic [IW-1:0] v);
		return irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::ADDR_W'(v) * irq_ctrl_pkg::VEC_STEP; // R06
	endfunction

	// =====================================================================
	// Sticky source flags; a new event beats a clear in the same cycle.
	logic [NUM_SRC-1:0] flag_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= (flag_reg & ~src_clear) | src_event; // R09
		end
	end
	assign src_flags = flag_reg;

	// =====================================================================
	// Gather enabled flags per vector and give each its programmed level.
	logic [NUM_VEC-1:0] vec_pend;
	logic [NUM_VEC*2-1:0] vec_level;
	always_comb begin
		vec_pend = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			if (flag_reg[s] && src_enable[s]) begin // R05 R07 R09
				vec_pend[vec_of(s)] = 1'b1;
			end
		end
		for (int v = 0; v < NUM_VEC; v++) begin
			if (!vec_pend[v]) begin
				vec_level[v*2 +: 2] = irq_ctrl_pkg::LVL_NONE;
			end else if (!vec_level_sel[v]) begin
				vec_level[v*2 +: 2] = irq_ctrl_pkg::LVL_LOW; // R01
			end else if (v < irq_ctrl_pkg::NUM_TOP_VEC) begin
				vec_level[v*2 +: 2] = irq_ctrl_pkg::LVL_TOP; // R06
			end else begin
				vec_level[v*2 +: 2] = irq_ctrl_pkg::LVL_HIGH; // R06
			end
		end
	end

	// =====================================================================
	// Arbitration against the current service level.
	logic win_valid;
	logic [IW-1:0] win_idx;
	logic [1:0] win_level;
	irq_arbiter #(.NUM_VEC(NUM_VEC), .IDX_W(IW)) u_arb (
		.vec_level(vec_level),
		.service_level(service_level),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_level(win_level)
	);

	// =====================================================================
	// Registered request to the core, refreshed every cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			core_req <= '0;
		end else begin
			core_req.valid <= win_valid && !core_ack; // R02
			core_req.idx <= win_idx;
			core_req.addr <= vec_addr(win_idx);
			core_req.level <= win_level;
		end
	end

	// =====================================================================
	// Stack of service levels; three levels nest at most three deep.
	// Bit k set means level k+1 is in service; the top set bit is the current level.
	logic [2:0] active_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			active_reg <= 3'h0;
		end else if (core_ack && core_req.valid) begin
			active_reg[core_req.level - 2'd1] <= 1'b1; // R02
		end else if (core_return) begin
			if (active_reg[2]) begin
				active_reg[2] <= 1'b0;
			end else if (active_reg[1]) begin
				active_reg[1] <= 1'b0;
			end else begin
				active_reg[0] <= 1'b0;
			end
		end
	end

	always_comb begin
		if (active_reg[2]) begin
			service_level = irq_ctrl_pkg::LVL_TOP;
		end else if (active_reg[1]) begin
			service_level = irq_ctrl_pkg::LVL_HIGH;
		end else if (active_reg[0]) begin
			service_level = irq_ctrl_pkg::LVL_LOW;
		end else begin
			service_level = irq_ctrl_pkg::LVL_NONE;
		end
	end

	// =====================================================================
	// Flag list for a chosen vector, registered.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			vector_source_flag_list <= '0;
		end else begin
			for (int s = 0; s < NUM_SRC; s++) begin
				vector_source_flag_list[s] <= flag_reg[s] && (vec_of(s) == list_vec); // R08
			end
		end
	end

	// =====================================================================
	// Checks.
	property p_no_lower_grant;
		@(posedge clk_sys) disable iff (rst)
		core_req.valid |-> core_req.level > $past(service_level);
	endproperty
	a_no_lower_grant: assert property (p_no_lower_grant) else $error("Request not above service level."); // R02

	// The address is taken apart again into base and whole steps, so a wrong product is caught.
	property p_addr_map;
		@(posedge clk_sys) disable iff (rst)
		core_req.valid |-> ((core_req.addr - irq_ctrl_pkg::VEC_BASE) % irq_ctrl_pkg::VEC_STEP == '0)
			&& ((core_req.addr - irq_ctrl_pkg::VEC_BASE) / irq_ctrl_pkg::VEC_STEP
			== irq_ctrl_pkg::ADDR_W'(core_req.idx));
	endproperty
	a_addr_map: assert property (p_addr_map) else $error("Vector address wrong."); // R06

	// No request may point past the last vector.
	property p_addr_range;
		@(posedge clk_sys) disable iff (rst)
		core_req.valid |-> core_req.addr <= irq_ctrl_pkg::VEC_BASE
			+ irq_ctrl_pkg::ADDR_W'(NUM_VEC - 1) * irq_ctrl_pkg::VEC_STEP;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("Vector address out of range."); // R06

	// Only the two pin vectors may ever be offered at the top level.
	property p_top_pair;
		@(posedge clk_sys) disable iff (rst)
		(core_req.valid && core_req.idx >= IW'(irq_ctrl_pkg::NUM_TOP_VEC))
			|-> core_req.level != irq_ctrl_pkg::LVL_TOP;
	endproperty
	a_top_pair: assert property (p_top_pair) else $error("Top level on a non-pin vector."); // R06

	property p_flag_sticky;
		@(posedge clk_sys) disable iff (rst)
		(flag_reg[0] && !src_clear[0]) |=> flag_reg[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("Flag dropped without clear."); // R09

	property p_set_wins;
		@(posedge clk_sys) disable iff (rst)
		src_event[3] |=> flag_reg[3];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Event lost."); // R09

	property p_top_wins;
		@(posedge clk_sys) disable iff (rst)
		(vec_level[1:0] == 2'b11 && service_level == 2'b00 && !core_ack) |=> core_req.idx == 4'h0;
	endproperty
	a_top_wins: assert property (p_top_wins) else $error("Top level vector lost."); // R03

	property p_small_first;
		@(posedge clk_sys) disable iff (rst)
		(vec_pend[2] && vec_pend[3] && vec_level[5:4] == vec_level[7:6] && win_level == vec_level[5:4])
			|-> win_idx != 4'h3;
	endproperty
	a_small_first: assert property (p_small_first) else $error("Larger vector won a tie."); // R04

	property p_shared_vec;
		@(posedge clk_sys) disable iff (rst)
		(flag_reg[16] && src_enable[16]) |-> vec_pend[8];
	endproperty
	a_shared_vec: assert property (p_shared_vec) else $error("Timer six not on shared vector."); // R07

	property p_list;
		@(posedge clk_sys) disable iff (rst)
		(flag_reg[15] && list_vec == 4'h8) |=> vector_source_flag_list[15];
	endproperty
	a_list: assert property (p_list) else $error("Flag list missing source."); // R08

	property p_low_code;
		@(posedge clk_sys) disable iff (rst)
		(vec_pend[5] && !vec_level_sel[5]) |-> vec_level[11:10] == 2'b01;
	endproperty
	a_low_code: assert property (p_low_code) else $error("Low level code wrong."); // R01

	property p_count;
		@(posedge clk_sys) disable iff (rst)
		(flag_reg[21] && src_enable[21]) |-> vec_pend[9];
	endproperty
	a_count: assert property (p_count) else $error("Source map wrong."); // R05

	// A taken request must leave the core and raise the service level to its own level.
	sequence s_take;
		core_ack && core_req.valid;
	endsequence

	sequence s_entered;
		!core_req.valid && service_level == $past(core_req.level);
	endsequence

	property p_take_enters;
		@(posedge clk_sys) disable iff (rst)
		s_take |=> s_entered;
	endproperty
	a_take_enters: assert property (p_take_enters) else $error("Taken request did not enter service."); // R02

endmodule

// ### tb/core_model.sv
`timescale 1ns/100ps
// =====================================================================
// Core side of the request handshake.
module core_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Controller side.
	input wire irq_ctrl_pkg::irq_req_s core_req,
	output logic core_ack,
	output logic core_return,
	// Bench side: take after a delay, or end the innermost service.
	input wire logic take_go,
	input wire logic end_go,
	input wire logic [2:0] take_delay
);
	int wait_cnt_reg;

	// The core acks only a request still offered, so a slow take of a withdrawn vector is dropped.
	always_ff @(posedge clk_sys) begin
		core_ack <= !rst && !take_go && wait_cnt_reg == 0 && core_req.valid;
		core_return <= !rst && end_go;
		if (rst || wait_cnt_reg == 0) begin
			wait_cnt_reg <= -1;
		end else if (take_go) begin
			wait_cnt_reg <= int'(take_delay);
		end else if (wait_cnt_reg > 0) begin
			wait_cnt_reg <= wait_cnt_reg - 1;
		end
	end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
	// =====================================================================
	// Signals and reference state.
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [21:0] src_event, src_enable, src_clear, vector_source_flag_list, src_flags;
	logic [9:0] vec_level_sel;
	logic [3:0] list_vec;
	logic take_go, end_go, core_ack, core_return;
	logic [2:0] take_delay;
	logic [1:0] service_level;
	irq_ctrl_pkg::irq_req_s core_req;
	logic [21:0] m_flags;
	logic [2:0] m_stack;
	int failures, checks_done;
	int vmap[22] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 8, 8, 8, 9, 9};

	// Free-running system clock.
	always #12.5 clk_sys = ~clk_sys;

	multilevel_vectored_irq_ctrl multilevel_vectored_irq_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
		.src_event(src_event), .src_enable(src_enable), .src_clear(src_clear), .vec_level_sel(vec_level_sel),
		.core_ack(core_ack), .core_return(core_return), .core_req(core_req), .list_vec(list_vec),
		.vector_source_flag_list(vector_source_flag_list), .src_flags(src_flags), .service_level(service_level));
	core_model core_model_inst (.clk_sys(clk_sys), .rst(rst), .core_req(core_req), .core_ack(core_ack),
		.core_return(core_return), .take_go(take_go), .end_go(end_go), .take_delay(take_delay));

	// =====================================================================
	// Reference model and checks.
	function automatic int svc();
		for (int l = 3; l >= 1; l--) begin
			if (m_stack[l-1]) return l;
		end
		return 0;
	endfunction

	// Ascending scan with strict compare keeps the smallest vector on a tie.
	task automatic win(output int w, output int wl);
		int l;
		w = -1;
		wl = svc();
		for (int s = 0; s < 22; s++) begin
			l = vec_level_sel[vmap[s]] ? (vmap[s] < 2 ? 3 : 2) : 1;
			if (m_flags[s] && src_enable[s] && (l > wl || (l == wl && w > vmap[s] && w >= 0))) begin
				w = vmap[s];
				wl = l;
			end
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic check_all();
		int w, wl;
		logic [21:0] lm;
		win(w, wl);
		lm = '0;
		for (int s = 0; s < 22; s++) begin
			lm[s] = (vmap[s] == int'(list_vec)) && m_flags[s];
		end
		chk(32'(core_req.valid), 32'(w >= 0));
		if (w >= 0) begin
			chk(32'(core_req.idx), 32'(w));
			chk(32'(core_req.addr), 32'h3 + 32'h8 * 32'(w));
			chk(32'(core_req.level), 32'(wl));
		end
		chk(32'(src_flags), 32'(m_flags));
		chk(32'(service_level), 32'(svc()));
		chk(32'(vector_source_flag_list), 32'(lm));
	endtask

	// Inputs move on the falling edge; results are compared once settled.
	task automatic step(input logic [21:0] ev, input logic [21:0] clr);
		src_event = ev;
		src_clear = clr;
		m_flags = (m_flags & ~clr) | ev;
		@(negedge clk_sys);
		src_event = '0;
		src_clear = '0;
		repeat (3) @(negedge clk_sys);
		check_all();
	endtask

	task automatic take(input int d);
		int w, wl;
		win(w, wl);
		take_go = 1'b1;
		take_delay = 3'(d);
		@(negedge clk_sys);
		take_go = 1'b0;
		repeat (d + 4) @(negedge clk_sys);
		if (w >= 0) m_stack[wl-1] = 1'b1;
		check_all();
	endtask

	task automatic give_back();
		end_go = 1'b1;
		@(negedge clk_sys);
		end_go = 1'b0;
		m_stack[svc()-1] = 1'b0;
		repeat (3) @(negedge clk_sys);
		check_all();
	endtask

	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// =====================================================================
	// Main sequence: each source alone, then random nesting traffic.
	initial begin
		{src_event, src_clear, src_enable, vec_level_sel, list_vec} = '0;
		{take_go, end_go, take_delay, m_flags, m_stack, failures, checks_done} = '0;
		void'($urandom(26209));
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		check_all();
		src_enable = '1;
		vec_level_sel = '1;
		for (int s = 0; s < 22; s++) begin
			list_vec = 4'(vmap[s]);
			step(22'h1 << s, '0);
			step('0, 22'h1 << s);
		end
		for (int i = 0; i < 400; i++) begin
			src_enable = 22'($urandom);
			if (i % 8 == 0) vec_level_sel = 10'($urandom);
			list_vec = 4'($urandom_range(9));
			step(22'($urandom & $urandom & $urandom), 22'($urandom & $urandom));
			if ($urandom_range(2) == 0) take($urandom_range(5));
			else if (m_stack != 0 && $urandom_range(1) == 0) give_back();
		end
		close_out();
	end

	// A hang ends the run as a failure.
	initial begin
		repeat (90000) @(posedge clk_sys);
		failures++;
		close_out();
	end
endmodule
